// ==== logic/processor_debug_port.v ====
`timescale 1ns/10ps
`include "processor_debug_port_consts.vh"

module processor_debug_port #(
  parameter [1:0] DEBUG_FORM = `FORM_SERIAL,
  parameter       SEL_W      = 8,
  parameter       TRIG_W     = 8,
  parameter       TRACE_W    = 36,
  parameter       TRACE_DEP  = 16,
  parameter       TRACE_AW   = 4
) (
  input  wire               clk_sys,
  input  wire               srst,
  input  wire               par_port_reset,
  input  wire               debug_rst,
  input  wire               dbg_clk,
  input  wire               dbg_tdi,
  input  wire [SEL_W-1:0]   dbg_reg_en,
  input  wire               dbg_shift,
  input  wire               dbg_capture,
  input  wire               dbg_update,
  output reg                dbg_tdo_ff,
  input  wire [7:0]         dbg_araddr,
  input  wire               dbg_arvalid,
  output reg                dbg_arready_ff,
  output reg  [31:0]        dbg_rdata_ff,
  output reg  [1:0]         dbg_rresp_ff,
  output reg                dbg_rvalid_ff,
  input  wire               dbg_rready,
  input  wire [7:0]         dbg_awaddr,
  input  wire               dbg_awvalid,
  output reg                dbg_awready_ff,
  input  wire [31:0]        dbg_wdata,
  input  wire               dbg_wvalid,
  output reg                dbg_wready_ff,
  output reg  [1:0]         dbg_bresp_ff,
  output reg                dbg_bvalid_ff,
  input  wire               dbg_bready,
  input  wire [TRIG_W-1:0]  core_trig_event,
  output reg  [TRIG_W-1:0]  dbg_trig_req_ff,
  input  wire [TRIG_W-1:0]  dbg_trig_req_ack,
  input  wire [TRIG_W-1:0]  dbg_trig_action,
  output reg  [TRIG_W-1:0]  dbg_trig_action_ack_ff,
  output reg  [TRIG_W-1:0]  core_trig_action_ff,
  input  wire               core_trace_valid,
  output reg                core_trace_ready_ff,
  input  wire [TRACE_W-1:0] core_trace_data,
  input  wire               dbg_trace_clk,
  output reg  [TRACE_W-1:0] dbg_trace_data_ff,
  output reg                dbg_trace_valid_ff,
  input  wire               dbg_trace_ready,
  output reg  [31:0]        dbg_ctrl_ff,
  input  wire [31:0]        core_status
);

  localparam USE_SER   = (DEBUG_FORM == `FORM_SERIAL);
  localparam USE_PAR   = (DEBUG_FORM != `FORM_SERIAL);
  localparam USE_EXTRA = (DEBUG_FORM != `FORM_PARALLEL_ONLY);

  // Write channel states, one-hot.
  localparam [1:0] WS_COLLECT = 2'b01; // Gathering address and data.
  localparam [1:0] WS_RESP    = 2'b10; // Holding the response.

  // Debug state clears on any of the three resets; the hub's reset is taken as a level
  // on this clock, so even a single-cycle pulse is seen.
  wire rst_dbg = srst | par_port_reset | debug_rst;

  // ------------------------------------------------------------------
  // Synchronisers for every signal that the serial and trace links drive.
  // ------------------------------------------------------------------
  reg [SEL_W+4:0] ser_s1_ff; // First stage, read only by the second.
  reg [SEL_W+4:0] ser_s2_ff; // Second stage, safe to use.
  reg             ser_clk_d_ff; // Previous synced serial clock.
  reg [1:0]       tr_s1_ff;  // First stage of trace clock and ready.
  reg [1:0]       tr_s2_ff;  // Second stage of trace clock and ready.
  reg             tr_clk_d_ff; // Previous synced trace clock.

  // Both links run on clocks of their own, so every level crosses two flops.
  always @(posedge clk_sys) begin
    if (srst) begin
      ser_s1_ff    <= {(SEL_W+5){1'b0}};
      ser_s2_ff    <= {(SEL_W+5){1'b0}};
      ser_clk_d_ff <= 1'b0;
      tr_s1_ff     <= 2'h0;
      tr_s2_ff     <= 2'h0;
      tr_clk_d_ff  <= 1'b0;
    end else begin
      ser_s1_ff    <= {dbg_reg_en, dbg_update, dbg_capture, dbg_shift, dbg_tdi, dbg_clk};
      ser_s2_ff    <= ser_s1_ff;
      ser_clk_d_ff <= ser_s2_ff[0];
      tr_s1_ff     <= {dbg_trace_ready, dbg_trace_clk};
      tr_s2_ff     <= tr_s1_ff;
      tr_clk_d_ff  <= tr_s2_ff[0];
    end
  end

  wire             ser_rise  = ser_s2_ff[0] & ~ser_clk_d_ff;
  wire             ser_tdi   = ser_s2_ff[1];
  wire             ser_shift = ser_s2_ff[2];
  wire             ser_capt  = ser_s2_ff[3];
  wire             ser_upd   = ser_s2_ff[4];
  wire [SEL_W-1:0] ser_sel   = ser_s2_ff[SEL_W+4:5];
  wire             tr_rise   = tr_s2_ff[0] & ~tr_clk_d_ff;
  wire             tr_fall   = ~tr_s2_ff[0] & tr_clk_d_ff;
  wire             tr_ready  = tr_s2_ff[1];

  // ------------------------------------------------------------------
  // Debug registers of the serial and parallel forms.
  // ------------------------------------------------------------------
  reg  [31:0] shift_ff;      // Serial shift register.
  reg  [7:0]  wr_addr_ff;    // Latched write address.
  reg  [31:0] wr_data_ff;    // Latched write data.
  reg         wr_addr_ok_ff; // Write address held.
  reg         wr_data_ok_ff; // Write data held.
  reg  [1:0]  wstate_ff;     // Write channel state.
  reg  [1:0]  nxt_wstate;    // Next write state.

  // Read view of the trigger lines: pending requests and live actions.
  wire [31:0] trig_view = {{(32-2*TRIG_W){1'b0}}, dbg_trig_action, dbg_trig_req_ff};

  // Map a parallel offset to register contents; unknown offsets read zero.
  function [31:0] par_read;
    input [7:0] addr;
    begin
      case (addr)
        `OFF_CTRL:   par_read = dbg_ctrl_ff;
        `OFF_STATUS: par_read = core_status;
        `OFF_TRIG:   par_read = trig_view;
        default:     par_read = 32'h0000_0000;
      endcase
    end
  endfunction

  // Control is read-write, the status and trigger views are read-only; the rest is unmapped.
  function par_known;
    input [7:0] addr;
    begin
      par_known = (addr == `OFF_CTRL) || (addr == `OFF_STATUS) || (addr == `OFF_TRIG);
    end
  endfunction

  wire wr_fire = wr_addr_ok_ff && wr_data_ok_ff && (wstate_ff == WS_COLLECT);
  wire wr_ctrl = wr_fire && (wr_addr_ff == `OFF_CTRL);
  wire ser_upd_ctrl = USE_SER && ser_rise && ser_upd && (ser_sel == `SEL_CTRL);

  // Control register: written by the serial update or by a parallel write.
  always @(posedge clk_sys) begin
    if (rst_dbg) begin
      dbg_ctrl_ff <= `CTRL_RESET;
    end else if (ser_upd_ctrl) begin
      dbg_ctrl_ff <= shift_ff;
    end else if (wr_ctrl) begin
      dbg_ctrl_ff <= wr_data_ff;
    end
  end

  // ------------------------------------------------------------------
  // Serial form: capture, shift and update on the hub's clock edges.
  // ------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst_dbg || !USE_SER) begin
      shift_ff   <= `SHIFT_RESET;
      dbg_tdo_ff <= 1'b0;
    end else if (ser_rise) begin
      if (ser_capt) begin
        // A capture loads the selected register for shifting out.
        case (ser_sel)
          `SEL_CTRL:   shift_ff <= dbg_ctrl_ff;
          `SEL_STATUS: shift_ff <= core_status;
          `SEL_TRIG:   shift_ff <= trig_view;
          default:     shift_ff <= `SHIFT_RESET;
        endcase
      end else if (ser_shift) begin
        // Least significant bit leaves first; new bits enter at the top.
        shift_ff   <= {ser_tdi, shift_ff[31:1]};
        dbg_tdo_ff <= shift_ff[0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Parallel form: read channel.
  // ------------------------------------------------------------------
  // One read is outstanding at a time; the address ready drops while the
  // answer waits, which throttles the hub without losing anything.
  always @(posedge clk_sys) begin
    if (rst_dbg || !USE_PAR) begin
      dbg_arready_ff <= 1'b0;
      dbg_rvalid_ff  <= 1'b0;
      dbg_rdata_ff   <= 32'h0000_0000;
      dbg_rresp_ff   <= `RESP_OKAY;
    end else if (dbg_rvalid_ff) begin
      if (dbg_rready) begin
        dbg_rvalid_ff  <= 1'b0;
        dbg_arready_ff <= 1'b1;
      end
    end else if (dbg_arready_ff && dbg_arvalid) begin
      dbg_arready_ff <= 1'b0;
      dbg_rvalid_ff  <= 1'b1;
      dbg_rdata_ff   <= par_read(dbg_araddr);
      dbg_rresp_ff   <= par_known(dbg_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else begin
      dbg_arready_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Parallel form: write channel, address and data taken independently.
  // ------------------------------------------------------------------
  always @* begin
    nxt_wstate = wstate_ff;
    case (wstate_ff)
      WS_COLLECT: begin
        if (wr_fire) begin
          nxt_wstate = WS_RESP;
        end
      end
      WS_RESP: begin
        if (dbg_bready) begin
          nxt_wstate = WS_COLLECT;
        end
      end
      default: nxt_wstate = WS_COLLECT;
    endcase
  end

  wire aw_take = dbg_awready_ff && dbg_awvalid;
  wire w_take  = dbg_wready_ff && dbg_wvalid;

  // Each half is held until both are present, then one write is done.
  always @(posedge clk_sys) begin
    if (rst_dbg || !USE_PAR) begin
      wstate_ff      <= WS_COLLECT;
      wr_addr_ok_ff  <= 1'b0;
      wr_data_ok_ff  <= 1'b0;
      wr_addr_ff     <= 8'h00;
      wr_data_ff     <= 32'h0000_0000;
      dbg_awready_ff <= 1'b0;
      dbg_wready_ff  <= 1'b0;
      dbg_bvalid_ff  <= 1'b0;
      dbg_bresp_ff   <= `RESP_OKAY;
    end else begin
      wstate_ff <= nxt_wstate;
      if (aw_take) begin
        wr_addr_ff    <= dbg_awaddr;
        wr_addr_ok_ff <= 1'b1;
      end
      if (w_take) begin
        wr_data_ff    <= dbg_wdata;
        wr_data_ok_ff <= 1'b1;
      end
      // Ready stays low for a half already held, and during the response.
      dbg_awready_ff <= (wstate_ff == WS_COLLECT) && !wr_addr_ok_ff && !aw_take && !wr_fire;
      dbg_wready_ff  <= (wstate_ff == WS_COLLECT) && !wr_data_ok_ff && !w_take && !wr_fire;
      if (wr_fire) begin
        wr_addr_ok_ff <= 1'b0;
        wr_data_ok_ff <= 1'b0;
        dbg_bvalid_ff <= 1'b1;
        dbg_bresp_ff  <= (wr_addr_ff == `OFF_CTRL) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (dbg_bvalid_ff && dbg_bready) begin
        dbg_bvalid_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Cross triggers, one bit per channel.
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < TRIG_W; gi = gi + 1) begin : g_trig
      reg action_seen_ff; // Action already passed to the core.
      // An event held as a request until the hub acknowledges it; a new
      // event in the acknowledge cycle wins, so none is lost.
      always @(posedge clk_sys) begin
        if (rst_dbg || !USE_EXTRA) begin
          dbg_trig_req_ff[gi]        <= 1'b0;
          dbg_trig_action_ack_ff[gi] <= 1'b0;
          core_trig_action_ff[gi]    <= 1'b0;
          action_seen_ff             <= 1'b0;
        end else begin
          if (core_trig_event[gi]) begin
            dbg_trig_req_ff[gi] <= 1'b1;
          end else if (dbg_trig_req_ack[gi]) begin
            dbg_trig_req_ff[gi] <= 1'b0;
          end
          // Each action request gives one pulse to the core and an
          // acknowledge held until the hub drops the request.
          core_trig_action_ff[gi]    <= dbg_trig_action[gi] && !action_seen_ff;
          action_seen_ff             <= dbg_trig_action[gi];
          dbg_trig_action_ack_ff[gi] <= dbg_trig_action[gi] && action_seen_ff;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // External program trace, buffered and handed out on the trace clock.
  // ------------------------------------------------------------------
  wire               fifo_in_ready;
  wire               fifo_out_valid;
  wire [TRACE_W-1:0] fifo_out_data;
  // New words are loaded only after a falling trace edge, two to three system
  // clocks after the fall, so data is settled before the hub samples it on the rising edge.
  wire               tr_load = tr_fall && !dbg_trace_valid_ff && fifo_out_valid;

  trace_fifo #(
    .WIDTH (TRACE_W),
    .DEPTH (TRACE_DEP),
    .AW    (TRACE_AW)
  ) u_trace_fifo (
    .clk_sys   (clk_sys),
    .srst      (rst_dbg),
    .in_valid  (core_trace_valid && core_trace_ready_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (core_trace_data),
    .out_valid (fifo_out_valid),
    .out_ready (tr_load),
    .out_data  (fifo_out_data)
  );

  // Back-pressure to the core; a full FIFO stalls the trace source.
  always @(posedge clk_sys) begin
    if (rst_dbg || !USE_EXTRA) begin
      core_trace_ready_ff <= 1'b0;
      dbg_trace_valid_ff  <= 1'b0;
      dbg_trace_data_ff   <= {TRACE_W{1'b0}};
    end else begin
      // Ready drops after every taken word, so a full buffer is never written.
      core_trace_ready_ff <= fifo_in_ready && !(core_trace_valid && core_trace_ready_ff);
      if (tr_rise && dbg_trace_valid_ff && tr_ready) begin
        dbg_trace_valid_ff <= 1'b0;
      end else if (tr_load) begin
        dbg_trace_valid_ff <= 1'b1;
        dbg_trace_data_ff  <= fifo_out_data;
      end
    end
  end

endmodule // processor_debug_port

// ==== logic/processor_debug_port_consts.vh ====
`ifndef PROCESSOR_DEBUG_PORT_CONSTS_VH
`define PROCESSOR_DEBUG_PORT_CONSTS_VH

// Debug port forms chosen at build time.
`define FORM_SERIAL        2'h0
`define FORM_PARALLEL      2'h1
`define FORM_PARALLEL_ONLY 2'h2

// Byte offsets of the debug registers on the parallel port.
`define OFF_CTRL           8'h00
`define OFF_STATUS         8'h04
`define OFF_TRIG           8'h08

// Serial register enable codes that select a debug register.
`define SEL_CTRL           8'h01
`define SEL_STATUS         8'h02
`define SEL_TRIG           8'h03

// Reset values.
`define CTRL_RESET         32'h0000_0000
`define SHIFT_RESET        32'h0000_0000

// Response codes of the parallel port.
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

// Timing: shortest debug reset pulse and the system clock period.
`define CLK_PERIOD_NS      100
`define DBG_RST_MIN_NS     100
`define DBG_RST_MIN_CYC    ((`DBG_RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== logic/trace_fifo.v ====
`timescale 1ns/10ps
// Synchronous FIFO holding trace words until the link takes them.
module trace_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys,
  input  wire             srst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array.
  reg [AW-1:0]    wr_ptr_ff;       // Next slot to write.
  reg [AW-1:0]    rd_ptr_ff;       // Next slot to read.
  reg [AW:0]      count_ff;        // Words held.

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  // Full and empty come straight from the count, so they never lie.
  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_ff];

  // Pointer and count bookkeeping.
  always @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // The array itself needs no reset; only counted words are read.
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

endmodule // trace_fifo

// ==== tb/debug_hub_model.sv ====
`timescale 1ns/10ps
// Stand-in for the debug module hub: trace clock and sink, trigger acknowledges.
module debug_hub_model #(
  parameter TRIG_W  = 8,
  parameter TRACE_W = 36
) (
  input  logic               clk_sys,
  input  logic               trace_run,
  input  logic               sink_open,
  input  logic [TRIG_W-1:0]  dbg_trig_req_ff,
  output logic [TRIG_W-1:0]  dbg_trig_req_ack,
  input  logic [TRACE_W-1:0] dbg_trace_data_ff,
  input  logic               dbg_trace_valid_ff,
  output logic               dbg_trace_clk,
  output logic               dbg_trace_ready
);
  logic [TRIG_W-1:0]  ack_dly;  // One cycle of delay makes the hub answer slowly.
  logic [TRACE_W-1:0] rx_q[$];  // Trace words taken off the link, oldest first.

  initial begin
    dbg_trace_clk = 1'b0;
    dbg_trace_ready = 1'b0;
    ack_dly = '0;
    dbg_trig_req_ack = '0;
  end

  // The trace clock runs only while a transfer is wanted and parks low between them.
  always #400 if (trace_run || dbg_trace_clk) dbg_trace_clk = ~dbg_trace_clk;

  // Ready moves only on the falling edge, so it is settled at every rising edge.
  always @(negedge dbg_trace_clk) dbg_trace_ready <= sink_open;

  // A word moves only at a rising edge where valid and ready are both high.
  always @(posedge dbg_trace_clk) begin
    if (dbg_trace_valid_ff && dbg_trace_ready) begin
      rx_q.push_back(dbg_trace_data_ff);
    end
  end

  // Each request is acknowledged two cycles after it rises, and the acknowledge falls a cycle after the request does.
  always @(posedge clk_sys) begin
    ack_dly <= dbg_trig_req_ff;
    dbg_trig_req_ack <= ack_dly & dbg_trig_req_ff;
  end
endmodule // debug_hub_model

// ==== tb/processor_debug_port_properties.sv ====
`timescale 1ns/10ps
// Watches the parallel port and the trigger pairs of the debug port from its pins.
module processor_debug_port_checker #(
  parameter TRIG_W = 8
) (
  input logic              clk_sys,
  input logic              srst,
  input logic              par_port_reset,
  input logic              debug_rst,
  input logic [7:0]        dbg_araddr,
  input logic              dbg_arvalid,
  input logic              dbg_arready_ff,
  input logic [31:0]       dbg_rdata_ff,
  input logic [1:0]        dbg_rresp_ff,
  input logic              dbg_rvalid_ff,
  input logic              dbg_rready,
  input logic [7:0]        dbg_awaddr,
  input logic              dbg_awvalid,
  input logic              dbg_awready_ff,
  input logic [31:0]       dbg_wdata,
  input logic              dbg_wvalid,
  input logic              dbg_wready_ff,
  input logic [1:0]        dbg_bresp_ff,
  input logic              dbg_bvalid_ff,
  input logic              dbg_bready,
  input logic [TRIG_W-1:0] core_trig_event,
  input logic [TRIG_W-1:0] dbg_trig_req_ff,
  input logic [TRIG_W-1:0] dbg_trig_req_ack,
  input logic [TRIG_W-1:0] dbg_trig_action,
  input logic [TRIG_W-1:0] dbg_trig_action_ack_ff,
  input logic [31:0]       dbg_ctrl_ff
);
  // Any of the three resets clears the port, so every check pauses under each of them.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst || par_port_reset || debug_rst);

  rd_take_a: assert property (dbg_arvalid && dbg_arready_ff |=> dbg_rvalid_ff && !dbg_arready_ff)
    else $error("read address taken without a read answer");
  rd_hold_a: assert property (dbg_rvalid_ff && !dbg_rready |=> dbg_rvalid_ff && $stable(dbg_rdata_ff))
    else $error("read answer dropped or changed before it was taken");
  rd_slverr_a: assert property (dbg_arvalid && dbg_arready_ff && !(dbg_araddr inside {8'h00, 8'h04, 8'h08})
    |=> dbg_rresp_ff == 2'h2 && dbg_rdata_ff == 32'h0000_0000)
    else $error("unmapped read not refused");
  wr_ctrl_a: assert property (dbg_awvalid && dbg_awready_ff && dbg_wvalid && dbg_wready_ff && dbg_awaddr == 8'h00
    |-> ##2 dbg_bvalid_ff && dbg_bresp_ff == 2'h0 && dbg_ctrl_ff == $past(dbg_wdata, 2))
    else $error("control write not completed");
  wr_slverr_a: assert property (dbg_awvalid && dbg_awready_ff && dbg_wvalid && dbg_wready_ff && dbg_awaddr != 8'h00
    |-> ##2 dbg_bvalid_ff && dbg_bresp_ff == 2'h2 && dbg_ctrl_ff == $past(dbg_ctrl_ff, 2))
    else $error("write to a read-only place not refused");
  wr_hold_a: assert property (dbg_bvalid_ff && !dbg_bready |=> dbg_bvalid_ff && $stable(dbg_bresp_ff))
    else $error("write response dropped before it was taken");
  trig_set_a: assert property (core_trig_event != 0 |=> (dbg_trig_req_ff & $past(core_trig_event)) == $past(core_trig_event))
    else $error("trigger event did not raise its request");
  trig_keep_a: assert property (!$past(srst || par_port_reset || debug_rst) && $past(dbg_trig_req_ff & ~dbg_trig_req_ack) != 0
    |-> (dbg_trig_req_ff | ~$past(dbg_trig_req_ff & ~dbg_trig_req_ack)) == {TRIG_W{1'b1}})
    else $error("trigger request dropped before its acknowledge");
  act_ack_a: assert property ($rose(dbg_trig_action[0]) |-> ##[2:3] dbg_trig_action_ack_ff[0])
    else $error("trigger action not acknowledged");
endmodule // processor_debug_port_checker

bind processor_debug_port processor_debug_port_checker #(.TRIG_W(TRIG_W)) u_chk (.*);

// ==== tb/tb_processor_debug_port.sv ====
`timescale 1ns/10ps
// Self-checking bench for the debug port in its parallel form and, through a twin, its serial form, with the hub model beside it.
module tb_processor_debug_port;
  logic        clk_sys = 1'b0, srst = 1'b1, debug_rst = 1'b0;
  logic        dbg_clk = 1'b0, dbg_tdi = 1'b0, dbg_shift = 1'b0, dbg_capture = 1'b0, dbg_update = 1'b0;
  logic [7:0]  dbg_reg_en = 8'h00, dbg_araddr = 8'h00, dbg_awaddr = 8'h00;
  logic        dbg_arvalid = 1'b0, dbg_rready = 1'b0, dbg_awvalid = 1'b0, dbg_wvalid = 1'b0, dbg_bready = 1'b0;
  logic [31:0] dbg_wdata = 32'h0000_0000, core_status = 32'h5A5A_C3C3;
  logic [7:0]  core_trig_event = 8'h00, dbg_trig_action = 8'h00, act_seen = 8'h00;
  logic        core_trace_valid = 1'b0, trace_run = 1'b0, sink_open = 1'b0;
  logic [35:0] core_trace_data = 36'h0_0000_0000;
  wire         dbg_tdo_ff, dbg_arready_ff, dbg_rvalid_ff, dbg_awready_ff, dbg_wready_ff, dbg_bvalid_ff, ser_tdo;
  wire  [31:0] dbg_rdata_ff, dbg_ctrl_ff, ser_ctrl;
  wire         par_port_reset = srst;
  wire  [1:0]  dbg_rresp_ff, dbg_bresp_ff;
  wire  [7:0]  dbg_trig_req_ff, dbg_trig_req_ack, dbg_trig_action_ack_ff, core_trig_action_ff;
  wire         core_trace_ready_ff, dbg_trace_clk, dbg_trace_valid_ff, dbg_trace_ready;
  wire  [35:0] dbg_trace_data_ff;
  int          n_errors = 0, tests_run = 0;

  processor_debug_port #(.DEBUG_FORM(2'h1)) DUT (.*);
  // A serial-form twin shares every input; only its serial results are watched.
  processor_debug_port #(.DEBUG_FORM(2'h0)) DUT_SER (.*, .dbg_tdo_ff(ser_tdo), .dbg_ctrl_ff(ser_ctrl),
    .dbg_arready_ff(), .dbg_rdata_ff(), .dbg_rresp_ff(), .dbg_rvalid_ff(), .dbg_awready_ff(), .dbg_wready_ff(),
    .dbg_bresp_ff(), .dbg_bvalid_ff(), .dbg_trig_req_ff(), .dbg_trig_action_ack_ff(), .core_trig_action_ff(),
    .core_trace_ready_ff(), .dbg_trace_data_ff(), .dbg_trace_valid_ff());
  debug_hub_model hub (.*);

  // The processor clock, 100 ns period, also clocks the parallel port.
  always #50 clk_sys = ~clk_sys;

  // Remembers every action pulse handed to the core.
  always @(posedge clk_sys) act_seen <= act_seen | core_trig_action_ff;

  task automatic final_report();
    $display("Errors %0d in %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // A wait that ran out is a fault, and nothing after it can be trusted.
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t wait ran out", $time);
      final_report();
    end
  endtask

  function automatic logic probe(input int k);
    case (k)
      0: probe = dbg_arready_ff;
      1: probe = dbg_rvalid_ff;
      2: probe = dbg_bvalid_ff;
      3: probe = dbg_trig_req_ff[3];
      default: probe = dbg_trig_action_ack_ff[5];
    endcase
  endfunction

  // Waits, at most 40 cycles, for an output to show the given level at a rising edge.
  task automatic await(input int k, input logic v);
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (probe(k) === v) break;
    end
    tmo(n < 40);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp_d, input logic [1:0] exp_r);
    @(posedge clk_sys);
    dbg_araddr <= a;
    dbg_arvalid <= 1'b1;
    await(0, 1'b1);
    dbg_arvalid <= 1'b0;
    dbg_rready <= 1'b1;
    await(1, 1'b1);
    dbg_rready <= 1'b0;
    chk(dbg_rdata_ff, exp_d);
    chk(dbg_rresp_ff, exp_r);
  endtask

  // Address and data are each released at the edge that takes them, independently.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_r);
    int  n;
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge clk_sys);
    dbg_awaddr <= a;
    dbg_wdata <= d;
    dbg_awvalid <= 1'b1;
    dbg_wvalid <= 1'b1;
    for (n = 0; n < 40 && (aw_p || w_p); n++) begin
      @(posedge clk_sys);
      if (dbg_awready_ff === 1'b1) aw_p = 1'b0;
      if (dbg_wready_ff === 1'b1) w_p = 1'b0;
      dbg_awvalid <= aw_p;
      dbg_wvalid <= w_p;
    end
    tmo(!aw_p && !w_p);
    dbg_bready <= 1'b1;
    await(2, 1'b1);
    dbg_bready <= 1'b0;
    chk(dbg_bresp_ff, exp_r);
  endtask

  // Register access, refusals and a read-only place, back to back.
  task automatic s_regs();
    chk(dbg_ctrl_ff, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000, 2'h0);
    rd(8'h04, core_status, 2'h0);
    wr(8'h00, 32'hA5A5_1234, 2'h0);
    rd(8'h00, 32'hA5A5_1234, 2'h0);
    wr(8'h04, 32'hFFFF_FFFF, 2'h2);
    wr(8'h0C, 32'h0000_0001, 2'h2);
    rd(8'h00, 32'hA5A5_1234, 2'h0);
    rd(8'h0C, 32'h0000_0000, 2'h2);
    rd(8'hFF, 32'h0000_0000, 2'h2);
  endtask

  // A one-cycle debug reset, then a processor reset that also resets the parallel port; each clears control.
  task automatic s_resets();
    int k;
    for (k = 0; k < 2; k++) begin
      wr(8'h00, 32'h0F0F_8001, 2'h0);
      @(posedge clk_sys);
      if (k == 0) debug_rst <= 1'b1;
      else srst <= 1'b1;
      @(posedge clk_sys);
      debug_rst <= 1'b0;
      srst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk(dbg_ctrl_ff, 32'h0000_0000);
      rd(8'h00, 32'h0000_0000, 2'h0);
    end
  endtask

  // An event request held until the hub answers; two actions acknowledged and passed on.
  task automatic s_trig();
    @(posedge clk_sys);
    core_trig_event <= 8'h08;
    @(posedge clk_sys);
    core_trig_event <= 8'h00;
    @(posedge clk_sys);
    chk(dbg_trig_req_ff, 8'h08);
    await(3, 1'b0);
    dbg_trig_action <= 8'h21;
    await(4, 1'b1);
    chk(dbg_trig_action_ack_ff, 8'h21);
    chk(act_seen, 8'h21);
    rd(8'h08, 32'h0000_2100, 2'h0);
    dbg_trig_action <= 8'h00;
    await(4, 1'b0);
    chk(dbg_trig_action_ack_ff, 8'h00);
  endtask

  // Fill the buffer with the link parked until it refuses, then drain with a stall midway.
  task automatic s_trace();
    int n, k;
    k = 0;
    core_trace_data <= {4'hA, 32'h0000_0000};
    core_trace_valid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (core_trace_ready_ff === 1'b1) begin
        k++;
        core_trace_data <= {4'hA, 32'(k)};
      end
    end
    core_trace_valid <= 1'b0;
    chk(k, 16);
    trace_run <= 1'b1;
    for (n = 0; n < 600 && hub.rx_q.size() < k; n++) begin
      @(posedge clk_sys);
      sink_open <= !(n >= 40 && n < 90);
    end
    tmo(n < 600);
    for (n = 0; n < k; n++) chk(hub.rx_q[n], {4'hA, 32'(n)});
    trace_run <= 1'b0;
  endtask

  // One 800 ns serial clock period; strobes and data bit are set up well ahead of the rise.
  task automatic ser_bit(input logic [3:0] c);
    {dbg_capture, dbg_shift, dbg_update, dbg_tdi} <= c;
    repeat (4) @(posedge clk_sys);
    dbg_clk <= 1'b1;
    repeat (4) @(posedge clk_sys);
    dbg_clk <= 1'b0;
  endtask

  // Serial form: capture control, shift a new word in while the old one leaves, update; twice.
  task automatic s_serial();
    int p, i;
    logic [31:0] v;
    v = 32'h9E37_4C1B;
    dbg_reg_en <= 8'h01;
    for (p = 0; p < 2; p++) begin
      ser_bit(4'h8);
      for (i = 0; i < 32; i++) begin
        ser_bit({3'h2, v[i] ^ p[0]});
        chk(ser_tdo, v[i] & p[0]);
      end
      ser_bit(4'h2);
      chk(ser_ctrl, v ^ {32{p[0]}});
    end
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    s_regs();
    s_resets();
    s_trig();
    s_serial();
    s_trace();
    final_report();
  end
endmodule // tb_processor_debug_port
